// ---- rtl/bpc_irq_detect.sv ----
// One external interrupt input: falling edge or low level
module bpc_irq_detect (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// Pin and mode
	input wire logic i_sel,
	input wire logic i_pin_n,
	input wire logic i_edge_mode,
	// Result
	output logic o_req,
	output logic o_event
);

	logic prev_n;
	logic next_req;

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			prev_n <= 1'b1;
		end else begin
			prev_n <= i_sel ? i_pin_n : 1'b1;
		end
	end

	// Edge mode sees only the high-to-low step; level follows the pin
	always_comb begin
		if (!i_sel) begin
			next_req = 1'b0;
		end else if (i_edge_mode) begin
			next_req = prev_n && !i_pin_n;
		end else begin
			next_req = !i_pin_n;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_req <= 1'b0;
		end else begin
			o_req <= next_req;
		end
	end

	// Event pulse for the sticky status: one per edge or level entry
	assign o_event = i_sel && prev_n && !i_pin_n;

endmodule : bpc_irq_detect

// ---- rtl/bpc_pkg.sv ----
package bpc_pkg;

	// ------------------------------------------------------------
	// Register offsets (byte address on the plain port)
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_BP_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_BP_MATCH_LO = 8'h04;
	localparam logic [7:0] ADDR_BP_MATCH_HI = 8'h08;
	localparam logic [7:0] ADDR_CORE_CTRL = 8'h0c;
	localparam logic [7:0] ADDR_PORT_A_ALT = 8'h10;
	localparam logic [7:0] ADDR_IRQ_TRIG = 8'h14;
	localparam logic [7:0] ADDR_PORT_A_OUT = 8'h18;
	localparam logic [7:0] ADDR_PORT_A_OE = 8'h1c;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h20;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h24;
	localparam logic [7:0] ADDR_PORT_A_IN = 8'h28;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int BP_HIT_BIT = 1;
	localparam int BP_ENABLE_BIT = 2;
	localparam int BP_PULSE_MODE_BIT = 3;
	localparam int CCS_CLK_TRISTATE_BIT = 1;
	localparam int CCS_SPEED_LSB = 3;
	localparam int IRQ_STS_BP_HIT = 0;
	localparam int IRQ_STS_EXT0 = 1;
	localparam int IRQ_STS_EXT1 = 2;

	// ------------------------------------------------------------
	// Reset values and widths
	// ------------------------------------------------------------
	localparam logic [7:0] BP_CONTROL_RST = 8'h00;
	localparam logic [7:0] CORE_CTRL_RST = 8'h00;
	localparam logic [1:0] SPEED_12MHZ = 2'h0;
	localparam logic [1:0] SPEED_24MHZ = 2'h1;
	localparam logic [1:0] SPEED_48MHZ = 2'h2;
	localparam logic [15:0] EXT_CODE_LIMIT = 16'h3fff;
	localparam int STS_W = 3;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int BP_PULSE_CORE_CLOCKS = 8;
	localparam logic [3:0] BP_PULSE_LEN = 4'(BP_PULSE_CORE_CLOCKS);

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} bpc_bus_req_t;

	typedef struct packed {
		logic [15:0] addr;
		logic code_fetch;
	} bpc_core_bus_t;

	typedef struct packed {
		logic irq0;
		logic irq1;
	} bpc_ext_irq_t;

endpackage : bpc_pkg

// ---- rtl/bpc_top.sv ----
module bpc_top (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// Register port
	input wire bpc_pkg::bpc_bus_req_t i_bus,
	output logic [7:0] o_rdata,
	// Core address bus and fetch routing
	input wire bpc_pkg::bpc_core_bus_t i_core,
	input wire logic i_ext_code_select,
	output logic o_fetch_external,
	// Breakpoint
	output logic o_breakpoint_out,
	// Clock output pin
	output logic o_core_clock_out,
	output logic o_core_clock_out_oe_n,
	output logic [1:0] o_core_speed,
	// Port A bits 0 and 1
	input wire logic [1:0] i_port_a_in,
	output logic [1:0] o_port_a_out,
	output logic [1:0] o_port_a_oe_n,
	// Interrupts
	output bpc_pkg::bpc_ext_irq_t o_ext_irq,
	output logic o_irq
);

	// ------------------------------------------------------------
	// Reset
	// ------------------------------------------------------------
	logic rst;
	assign rst = !i_rst_n;

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic bp_enable_bit;
	logic bp_pulse_mode_bit;
	logic bp_hit;
	logic [15:0] bp_match_address;
	logic [7:0] core_control_status;
	logic [1:0] port_a_alt_config;
	logic [1:0] irq_trigger_type;
	logic [1:0] port_a_out;
	logic [1:0] port_a_oe;
	logic [bpc_pkg::STS_W-1:0] irq_status;
	logic [bpc_pkg::STS_W-1:0] irq_mask;
	logic [3:0] pulse_cnt;
	logic bp_latched;
	logic bp_match;
	logic bp_event;
	logic [1:0] ext_req;
	logic [1:0] ext_event;
	logic [bpc_pkg::STS_W-1:0] sts_set;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	logic wr_ctrl;
	logic rd_sts;
	assign wr_ctrl = i_bus.wr && hit(i_bus.addr, bpc_pkg::ADDR_BP_CONTROL);
	assign rd_sts = i_bus.rd && hit(i_bus.addr, bpc_pkg::ADDR_IRQ_STATUS);

	// ------------------------------------------------------------
	// Breakpoint comparator
	// ------------------------------------------------------------
	// Address is compared every cycle regardless of target memory
	assign bp_match = (i_core.addr == bp_match_address);
	assign bp_event = bp_enable_bit && bp_match;

	always_ff @(posedge i_ref_clk) begin
		if (rst) begin
			bp_enable_bit <= bpc_pkg::BP_CONTROL_RST[bpc_pkg::BP_ENABLE_BIT];
			bp_pulse_mode_bit <=
				bpc_pkg::BP_CONTROL_RST[bpc_pkg::BP_PULSE_MODE_BIT];
		end else if (wr_ctrl) begin
			bp_enable_bit <= i_bus.wdata[bpc_pkg::BP_ENABLE_BIT];
			bp_pulse_mode_bit <= i_bus.wdata[bpc_pkg::BP_PULSE_MODE_BIT];
		end
	end

	// Hit flag: a new match beats a write-one clear in the same cycle
	always_ff @(posedge i_ref_clk) begin
		if (rst) begin
			bp_hit <= 1'b0;
		end else if (bp_event) begin
			bp_hit <= 1'b1;
		end else if (wr_ctrl && i_bus.wdata[bpc_pkg::BP_HIT_BIT]) begin
			bp_hit <= 1'b0;
		end
	end

	// Pulse counter counts reference clocks, so length is the same at every speed
	always_ff @(posedge i_ref_clk) begin
		if (rst || !bp_enable_bit) begin
			pulse_cnt <= 4'h0;
		end else if (bp_event && bp_pulse_mode_bit && pulse_cnt == 4'h0) begin
			pulse_cnt <= bpc_pkg::BP_PULSE_LEN;
		end else if (pulse_cnt != 4'h0) begin
			pulse_cnt <= pulse_cnt - 4'h1;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (rst || !bp_enable_bit) begin
			bp_latched <= 1'b0;
		end else if (bp_event && !bp_pulse_mode_bit) begin
			bp_latched <= 1'b1;
		end else if (wr_ctrl && i_bus.wdata[bpc_pkg::BP_HIT_BIT]) begin
			bp_latched <= 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (rst) begin
			o_breakpoint_out <= 1'b0;
		end else begin
			o_breakpoint_out <= bp_enable_bit &&
				(bp_latched || pulse_cnt != 4'h0);
		end
	end

	// ------------------------------------------------------------
	// Match address, core control, port A config
	// ------------------------------------------------------------
	// Bytes land one at a time: disable the comparator while both
	// halves are rewritten, or a half-new address may match
	always_ff @(posedge i_ref_clk) begin
		if (rst) begin
			bp_match_address <= 16'h0000;
		end else if (i_bus.wr) begin
			if (hit(i_bus.addr, bpc_pkg::ADDR_BP_MATCH_LO)) begin
				bp_match_address[7:0] <= i_bus.wdata;
			end
			if (hit(i_bus.addr, bpc_pkg::ADDR_BP_MATCH_HI)) begin
				bp_match_address[15:8] <= i_bus.wdata;
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (rst) begin
			core_control_status <= bpc_pkg::CORE_CTRL_RST;
		end else if (i_bus.wr && hit(i_bus.addr, bpc_pkg::ADDR_CORE_CTRL)) begin
			core_control_status <= i_bus.wdata;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (rst) begin
			port_a_alt_config <= 2'h0;
			irq_trigger_type <= 2'h0;
			port_a_out <= 2'h0;
			port_a_oe <= 2'h0;
		end else if (i_bus.wr) begin
			case (i_bus.addr)
				bpc_pkg::ADDR_PORT_A_ALT: port_a_alt_config <= i_bus.wdata[1:0];
				bpc_pkg::ADDR_IRQ_TRIG: irq_trigger_type <= i_bus.wdata[1:0];
				bpc_pkg::ADDR_PORT_A_OUT: port_a_out <= i_bus.wdata[1:0];
				bpc_pkg::ADDR_PORT_A_OE: port_a_oe <= i_bus.wdata[1:0];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (rst) begin
			irq_mask <= '0;
		end else if (i_bus.wr && hit(i_bus.addr, bpc_pkg::ADDR_IRQ_MASK)) begin
			irq_mask <= i_bus.wdata[bpc_pkg::STS_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// Code fetch routing
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (rst) begin
			o_fetch_external <= 1'b0;
		end else begin
			o_fetch_external <= i_core.code_fetch &&
				(i_ext_code_select ||
				i_core.addr > bpc_pkg::EXT_CODE_LIMIT);
		end
	end

	// ------------------------------------------------------------
	// Clock output
	// ------------------------------------------------------------
	// Divider from the reference; 48 MHz toggles every reference clock, the same rate as 24 MHz
	logic [1:0] div_cnt;
	logic [1:0] speed;
	assign speed = core_control_status[bpc_pkg::CCS_SPEED_LSB +: 2];

	always_ff @(posedge i_ref_clk) begin
		if (rst) begin
			div_cnt <= 2'h0;
		end else begin
			div_cnt <= div_cnt + 2'h1;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (rst) begin
			o_core_clock_out <= 1'b0;
			o_core_speed <= bpc_pkg::SPEED_12MHZ;
		end else begin
			o_core_speed <= speed;
			case (speed)
				bpc_pkg::SPEED_24MHZ: o_core_clock_out <= div_cnt[0];
				bpc_pkg::SPEED_48MHZ: o_core_clock_out <= !o_core_clock_out;
				default: o_core_clock_out <= div_cnt[1];
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (rst) begin
			o_core_clock_out_oe_n <= 1'b0;
		end else begin
			o_core_clock_out_oe_n <=
				core_control_status[bpc_pkg::CCS_CLK_TRISTATE_BIT];
		end
	end

	// ------------------------------------------------------------
	// Port A bits 0 and 1
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_pa
			// Alternate function forces input so the pin can be sampled
			assign o_port_a_oe_n[g] = port_a_alt_config[g] || !port_a_oe[g];
			assign o_port_a_out[g] = port_a_out[g];
			bpc_irq_detect u_det (
				.i_ref_clk(i_ref_clk),
				.i_rst(rst),
				.i_sel(port_a_alt_config[g]),
				.i_pin_n(i_port_a_in[g]),
				.i_edge_mode(irq_trigger_type[g]),
				.o_req(ext_req[g]),
				.o_event(ext_event[g])
			);
		end
	endgenerate

	assign o_ext_irq.irq0 = ext_req[0];
	assign o_ext_irq.irq1 = ext_req[1];

	// ------------------------------------------------------------
	// Interrupt status
	// ------------------------------------------------------------
	assign sts_set = {ext_event[1], ext_event[0], bp_event};

	// Set wins over clear-on-read so no event is lost
	always_ff @(posedge i_ref_clk) begin
		if (rst) begin
			irq_status <= '0;
		end else begin
			irq_status <= (rd_sts ? '0 : irq_status) | sts_set;
		end
	end

	assign o_irq = |(irq_status & irq_mask);

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (rst) begin
			o_rdata <= 8'h00;
		end else if (i_bus.rd) begin
			case (i_bus.addr)
				bpc_pkg::ADDR_BP_CONTROL: o_rdata <= {4'h0, bp_pulse_mode_bit,
					bp_enable_bit, bp_hit, 1'b0};
				bpc_pkg::ADDR_BP_MATCH_LO: o_rdata <= bp_match_address[7:0];
				bpc_pkg::ADDR_BP_MATCH_HI: o_rdata <= bp_match_address[15:8];
				bpc_pkg::ADDR_CORE_CTRL: o_rdata <= core_control_status;
				bpc_pkg::ADDR_PORT_A_ALT: o_rdata <= {6'h00, port_a_alt_config};
				bpc_pkg::ADDR_IRQ_TRIG: o_rdata <= {6'h00, irq_trigger_type};
				bpc_pkg::ADDR_PORT_A_OUT: o_rdata <= {6'h00, port_a_out};
				bpc_pkg::ADDR_PORT_A_OE: o_rdata <= {6'h00, port_a_oe};
				bpc_pkg::ADDR_IRQ_STATUS: o_rdata <= {5'h00, irq_status};
				bpc_pkg::ADDR_IRQ_MASK: o_rdata <= {5'h00, irq_mask};
				bpc_pkg::ADDR_PORT_A_IN: o_rdata <= {6'h00, i_port_a_in};
				default: o_rdata <= 8'h00;
			endcase
		end else begin
			o_rdata <= 8'h00;
		end
	end

endmodule : bpc_top

// ---- test/bpc_dbg_model.sv ----
module bpc_dbg_model (
	// Clock
	input wire logic i_ref_clk,
	// Device side
	input wire logic i_breakpoint,
	input wire logic [1:0] i_pin_out,
	input wire logic [1:0] i_pin_oe_n,
	// Far side levels and results
	input wire logic [1:0] i_level,
	output logic [1:0] o_pin,
	output logic [7:0] o_width
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] run = 8'h00;
	initial o_width = 8'h00;
	// Device wins where it drives, far side elsewhere
	assign o_pin = (i_pin_out & ~i_pin_oe_n) | (i_level & i_pin_oe_n);
	always @(posedge i_ref_clk) begin
		if (i_breakpoint) begin
			run <= run + 8'h01;
		end else begin
			if (run != 8'h00) o_width <= run;
			run <= 8'h00;
		end
	end
endmodule : bpc_dbg_model

// ---- test/bpc_sva.sv ----
module bpc_sva (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// Watched ports
	input wire bpc_pkg::bpc_bus_req_t i_bus,
	input wire logic [7:0] o_rdata,
	input wire bpc_pkg::bpc_core_bus_t i_core,
	input wire logic i_ext_code_select,
	input wire logic o_fetch_external,
	input wire logic o_breakpoint_out,
	input wire logic o_core_clock_out_oe_n,
	input wire logic [1:0] i_port_a_in,
	input wire bpc_pkg::bpc_ext_irq_t o_ext_irq
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	logic en, pm, ctl_wr, ccs_wr, hit, fexp;
	logic [15:0] mt;
	assign ctl_wr = i_bus.wr && i_bus.addr == bpc_pkg::ADDR_BP_CONTROL;
	assign ccs_wr = i_bus.wr && i_bus.addr == bpc_pkg::ADDR_CORE_CTRL;
	assign hit = en && i_core.addr == mt;
	assign fexp = i_core.code_fetch
		&& (i_ext_code_select || i_core.addr > bpc_pkg::EXT_CODE_LIMIT);
	// Shadow of the setup, so the checker needs no internal taps
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			en <= 1'b0;
			pm <= 1'b0;
			mt <= 16'h0000;
		end else begin
			if (ctl_wr) begin
				en <= i_bus.wdata[bpc_pkg::BP_ENABLE_BIT];
				pm <= i_bus.wdata[bpc_pkg::BP_PULSE_MODE_BIT];
			end
			if (i_bus.wr && i_bus.addr == bpc_pkg::ADDR_BP_MATCH_LO)
				mt[7:0] <= i_bus.wdata;
			if (i_bus.wr && i_bus.addr == bpc_pkg::ADDR_BP_MATCH_HI)
				mt[15:8] <= i_bus.wdata;
		end
	end
	sequence s_pulse;
		o_breakpoint_out [*8] ##1 !o_breakpoint_out;
	endsequence
	sequence s_quiet;
		!ctl_wr && !$past(ctl_wr);
	endsequence
	AST_BP_RISE: assert property (
		$rose(o_breakpoint_out) |-> $past(hit, 2))
		else $error("breakpoint rose without a match");
	AST_BP_PULSE: assert property (
		$rose(o_breakpoint_out) && pm |-> s_pulse)
		else $error("breakpoint pulse is not eight clocks");
	AST_BP_HOLD: assert property (
		o_breakpoint_out && !pm and s_quiet |=> o_breakpoint_out)
		else $error("latched breakpoint dropped uncleared");
	AST_BP_OFF: assert property (
		!en [*3] |-> !o_breakpoint_out)
		else $error("breakpoint high while disabled");
	AST_FETCH: assert property (
		1'b1 |=> o_fetch_external == $past(fexp))
		else $error("fetch routing wrong");
	AST_CLK_HIZ: assert property (
		ccs_wr && i_bus.wdata[bpc_pkg::CCS_CLK_TRISTATE_BIT]
		|-> ##[1:2] o_core_clock_out_oe_n)
		else $error("clock output not released");
	AST_CLK_DRV: assert property (
		ccs_wr && !i_bus.wdata[bpc_pkg::CCS_CLK_TRISTATE_BIT]
		|-> ##[1:2] !o_core_clock_out_oe_n)
		else $error("clock output not driven");
	AST_IRQ0: assert property (
		o_ext_irq.irq0 |-> !$past(i_port_a_in[0]))
		else $error("irq0 without low pin");
	AST_IRQ1: assert property (
		o_ext_irq.irq1 |-> !$past(i_port_a_in[1]))
		else $error("irq1 without low pin");
	AST_RDATA: assert property (
		!$past(i_bus.rd) |-> o_rdata == 8'h00)
		else $error("read data outside its cycle");
endmodule : bpc_sva

// ---- test/testbench.sv ----
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst_n = 1'b0, sel = 1'b0, bp, cko, cko_oe_n, fx, irq;
	bpc_pkg::bpc_bus_req_t bus = '0;
	bpc_pkg::bpc_core_bus_t core = '0;
	bpc_pkg::bpc_ext_irq_t xi;
	logic [7:0] rdata, width;
	logic [1:0] spd, pa_in, pa_out, pa_oe_n, lvl = 2'b11;
	int failures = 0, checks = 0;
	initial forever #5 clk = ~clk;
	bpc_top dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_bus(bus),
		.o_rdata(rdata), .i_core(core), .i_ext_code_select(sel),
		.o_fetch_external(fx), .o_breakpoint_out(bp),
		.o_core_clock_out(cko), .o_core_clock_out_oe_n(cko_oe_n),
		.o_core_speed(spd), .i_port_a_in(pa_in), .o_port_a_out(pa_out),
		.o_port_a_oe_n(pa_oe_n), .o_ext_irq(xi), .o_irq(irq));
	bpc_dbg_model u_dbg (.i_ref_clk(clk), .i_breakpoint(bp),
		.i_pin_out(pa_out), .i_pin_oe_n(pa_oe_n), .i_level(lvl),
		.o_pin(pa_in), .o_width(width));
	task automatic chk(input string n, input logic [15:0] s, e);
		checks++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic wr(input logic [7:0] a, d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '0;
	endtask : wr
	task automatic rd(input logic [7:0] a, e, input string n);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus <= '0;
		#1;
		chk(n, 16'(rdata), 16'(e));
	endtask : rd
	task automatic hit(input logic f);
		@(posedge clk);
		core <= '{addr: 16'h1234, code_fetch: f};
		@(posedge clk);
		core <= '0;
	endtask : hit
	task automatic t_reset;
		#1;
		chk("bp", 16'(bp), 16'h0);
		chk("pa oe", 16'(pa_oe_n), 16'h3);
		chk("clk oe", 16'(cko_oe_n), 16'h0);
		chk("speed", 16'(spd), 16'h0);
		rd(bpc_pkg::ADDR_BP_CONTROL, 8'h00, "ctl");
		rd(bpc_pkg::ADDR_IRQ_STATUS, 8'h00, "sts");
	endtask : t_reset
	task automatic toggles(input int e, input string n);
		int t;
		logic p;
		t = 0;
		cyc(1);
		p = cko;
		repeat (32) begin
			cyc(1);
			if (cko !== p) t++;
			p = cko;
		end
		chk(n, 16'(t), 16'(e));
	endtask : toggles
	task automatic t_clock;
		toggles(16, "toggles 12");
		wr(bpc_pkg::ADDR_CORE_CTRL, 8'h02);
		cyc(2);
		chk("clk hiz", 16'(cko_oe_n), 16'h1);
		wr(bpc_pkg::ADDR_CORE_CTRL, 8'h08);
		cyc(2);
		chk("speed", 16'(spd), 16'h1);
		chk("clk drv", 16'(cko_oe_n), 16'h0);
		toggles(32, "toggles 24");
		wr(bpc_pkg::ADDR_CORE_CTRL, 8'h10);
		cyc(2);
		chk("speed", 16'(spd), 16'h2);
		toggles(32, "toggles 48");
		wr(bpc_pkg::ADDR_CORE_CTRL, 8'h00);
	endtask : t_clock
	task automatic t_fetch;
		logic [16:0] tab [4] = '{17'h00000, 17'h03fff, 17'h04000, 17'h13fff};
		foreach (tab[i]) begin
			@(posedge clk);
			core <= '{addr: tab[i][15:0], code_fetch: 1'b1};
			sel <= tab[i][16];
			@(posedge clk);
			core <= '0;
			#1;
			chk("fetch", 16'(fx),
				16'(tab[i][16] || tab[i][15:14] != 2'h0));
		end
	endtask : t_fetch
	task automatic t_pulse;
		wr(bpc_pkg::ADDR_BP_MATCH_LO, 8'h34);
		wr(bpc_pkg::ADDR_BP_MATCH_HI, 8'h12);
		wr(bpc_pkg::ADDR_IRQ_MASK, 8'h01);
		wr(bpc_pkg::ADDR_BP_CONTROL, 8'h0c);
		hit(1'b0);
		#1;
		chk("bp early", 16'(bp), 16'h0);
		cyc(1);
		chk("bp rise", 16'(bp), 16'h1);
		cyc(12);
		chk("width", 16'(width), 16'd8);
		chk("irq", 16'(irq), 16'h1);
		rd(bpc_pkg::ADDR_IRQ_STATUS, 8'h01, "sts");
		chk("irq clr", 16'(irq), 16'h0);
		rd(bpc_pkg::ADDR_BP_CONTROL, 8'h0e, "hit");
	endtask : t_pulse
	task automatic t_latch;
		wr(bpc_pkg::ADDR_IRQ_MASK, 8'h00);
		wr(bpc_pkg::ADDR_BP_CONTROL, 8'h06);
		wr(bpc_pkg::ADDR_BP_CONTROL, 8'h04);
		hit(1'b1);
		cyc(20);
		chk("held", 16'(bp), 16'h1);
		chk("masked", 16'(irq), 16'h0);
		wr(bpc_pkg::ADDR_BP_CONTROL, 8'h06);
		cyc(3);
		chk("cleared", 16'(bp), 16'h0);
		rd(bpc_pkg::ADDR_IRQ_STATUS, 8'h01, "sts");
		wr(bpc_pkg::ADDR_BP_CONTROL, 8'h00);
		hit(1'b1);
		cyc(4);
		chk("off", 16'(bp), 16'h0);
		rd(bpc_pkg::ADDR_BP_CONTROL, 8'h00, "no hit");
		wr(bpc_pkg::ADDR_BP_CONTROL, 8'h04);
		hit(1'b1);
		cyc(4);
		chk("latched", 16'(bp), 16'h1);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
	endtask : t_latch
	task automatic t_irq;
		int n;
		n = 0;
		wr(bpc_pkg::ADDR_PORT_A_ALT, 8'h03);
		wr(bpc_pkg::ADDR_IRQ_TRIG, 8'h00);
		wr(bpc_pkg::ADDR_IRQ_MASK, 8'h06);
		lvl <= 2'b10;
		cyc(3);
		chk("lvl irq0", 16'(xi.irq0), 16'h1);
		chk("irq", 16'(irq), 16'h1);
		@(posedge clk);
		lvl <= 2'b11;
		cyc(2);
		chk("lvl off", 16'(xi.irq0), 16'h0);
		rd(bpc_pkg::ADDR_IRQ_STATUS, 8'h02, "sts0");
		wr(bpc_pkg::ADDR_IRQ_TRIG, 8'h03);
		lvl <= 2'b01;
		repeat (6) begin
			cyc(1);
			if (xi.irq1 === 1'b1) n++;
		end
		chk("edge irq1", 16'(n), 16'h1);
		rd(bpc_pkg::ADDR_IRQ_STATUS, 8'h04, "sts1");
		@(posedge clk);
		lvl <= 2'b11;
		wr(bpc_pkg::ADDR_PORT_A_ALT, 8'h00);
		wr(bpc_pkg::ADDR_PORT_A_OUT, 8'h00);
		wr(bpc_pkg::ADDR_PORT_A_OE, 8'h01);
		cyc(1);
		chk("pa oe", 16'(pa_oe_n), 16'h2);
		rd(bpc_pkg::ADDR_PORT_A_IN, 8'h02, "pa in");
		rd(8'h30, 8'h00, "unmapped");
	endtask : t_irq
	task automatic stop_test;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test
	initial begin
		#100000;
		failures++;
		stop_test();
	end
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_clock();
		t_fetch();
		t_pulse();
		t_latch();
		t_irq();
		stop_test();
	end
endmodule : testbench
bind bpc_top bpc_sva u_sva (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
	.i_bus(i_bus), .o_rdata(o_rdata), .i_core(i_core),
	.i_ext_code_select(i_ext_code_select),
	.o_fetch_external(o_fetch_external),
	.o_breakpoint_out(o_breakpoint_out),
	.o_core_clock_out_oe_n(o_core_clock_out_oe_n),
	.i_port_a_in(i_port_a_in), .o_ext_irq(o_ext_irq));
